// file: verilog/fbls_pkg.sv
// constants and types shared by the burst flash timing and status block
package fbls_pkg;
  localparam int CLK_MHZ          = 50;
  localparam int WORD_PROG_US     = 40;
  localparam int WORD_PROG_MAX_US = 400;
  localparam int WORD_PROG_CYC    = WORD_PROG_US * CLK_MHZ;
  localparam int BUF_PROG_US      = 300;
  localparam int BUF_PROG_MAX_US  = 3000;
  localparam int BUF_PROG_CYC     = BUF_PROG_US * CLK_MHZ;
  localparam int SECT_ERASE_MS    = 600;
  localparam longint SECT_ERASE_CYC = longint'(SECT_ERASE_MS) * 1000 * CLK_MHZ;
  localparam int CHIP_ERASE_S     = 308;
  localparam longint CHIP_ERASE_CYC = longint'(CHIP_ERASE_S) * 1000000 * CLK_MHZ;
  localparam int TMR_W            = 36;
  localparam int BUF_WORDS        = 32;

  localparam int CFG_RDY_BIT      = 8;
  localparam int CFG_WAIT_LSB     = 11;
  localparam int CFG_WAIT_W       = 3;
  localparam logic [15:0] CFG_RESET = 16'h2900;
  localparam logic [2:0] WAIT_MAX   = 3'h5;
  localparam logic [3:0] WAIT_EXTRA = 4'h2;
  localparam logic [6:0] BOUND_MASK = 7'h7F;

  localparam int BUSY_TOG_BIT     = 6;
  localparam int SUSP_TOG_BIT     = 2;
  localparam logic [15:0] PREPROG_VAL = 16'h0000;
  localparam logic [15:0] ERASED_VAL  = 16'hFFFF;

  typedef enum logic [2:0] {
    CMD_PROGRAM    = 3'h0,
    CMD_BUF_LOAD   = 3'h1,
    CMD_BUF_COMMIT = 3'h2,
    CMD_SECT_ERASE = 3'h3,
    CMD_CHIP_ERASE = 3'h4,
    CMD_SUSPEND    = 3'h5,
    CMD_RESUME     = 3'h6,
    CMD_SET_CFG    = 3'h7
  } fbls_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PREPROG = 3'h1,
    ST_ERASE   = 3'h3,
    ST_SUSP    = 3'h7,
    ST_PROG    = 3'h4,
    ST_BUFPROG = 3'h2
  } fbls_state_e;
endpackage

// file: verilog/fbls_top.sv
// burst read latency, toggle status and embedded program/erase engine
// Notes on behaviour
// [RULE1] suspend toggle only inside erase-suspended sector
// [RULE2] host pulses oe or ce between reads
// [RULE3] ready with data, or one cycle early
// [RULE4] boundary above 66 MHz, wait<=5: no waits
// [RULE5] boundary every 128 words, also word zero
// [RULE6] wait code: 5/7, 4/6, 3/5; 6,7 reserved
// [RULE7] other banks readable while one bank busy
// [RULE8] host reads busy status twice, compares
// [RULE9] erase first programs area to zero
// [RULE10] chip erase within 308 s
// [RULE11] word program 40 us typical, 400 max
// [RULE12] 32-word buffer 300 us typical, 3000 max
// [RULE13] toggling stops once algorithm finishes
// [RULE14] host polls until two reads agree
`timescale 1ns/1ns

module fbls_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] m;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 n;
  } fbls_fifo_s;

  fbls_fifo_s f;
  fbls_fifo_s next_f;
  logic       push;
  logic       pop;

  assign in_ready  = f.n != (AW+1)'(DEPTH);
  assign out_valid = f.n != '0;
  assign out_data  = f.m[f.rp];

  always_comb begin
    next_f = f;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push) begin
      next_f.m[f.wp] = in_data;
      next_f.wp      = (f.wp == AW'(DEPTH - 1)) ? '0 : f.wp + AW'(1);
    end
    if (pop) begin
      next_f.rp = (f.rp == AW'(DEPTH - 1)) ? '0 : f.rp + AW'(1);
    end
    next_f.n = f.n + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end
endmodule

module fbls_top #(
  parameter int ADDR_W    = 24,
  parameter int MEM_AW    = 8,
  parameter int BANK_W    = 2,
  parameter int SECT_W    = 4,
  parameter int BUF_DEPTH = fbls_pkg::BUF_WORDS,
  parameter logic [fbls_pkg::TMR_W-1:0] BUF_PROG_CYCLES =
    fbls_pkg::TMR_W'(fbls_pkg::BUF_PROG_CYC),
  parameter logic [fbls_pkg::TMR_W-1:0] SECT_ERASE_CYCLES =
    fbls_pkg::TMR_W'(fbls_pkg::SECT_ERASE_CYC),
  parameter logic [fbls_pkg::TMR_W-1:0] CHIP_ERASE_CYCLES =
    fbls_pkg::TMR_W'(fbls_pkg::CHIP_ERASE_CYC)
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              burst_clk,
  input  wire logic              ce_n,
  input  wire logic              adv_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [2:0]        cmd_op,
  input  wire logic [15:0]       dq_in,
  output logic      [15:0]       dq_out,
  output logic                   dq_oe,
  output logic                   rdy,
  output logic                   cmd_ready
);
  localparam int WORDS = 2 ** MEM_AW;
  localparam int TW    = fbls_pkg::TMR_W;

  typedef struct packed {
    logic [1:0]        ack_sy;
    logic [1:0]        busy_sy;
    logic [1:0]        susp_sy;
    logic              req;
    fbls_pkg::fbls_cmd_e op;
    logic [ADDR_W-1:0] caddr;
    logic [15:0]       cdata;
    logic [15:0]       cfg;
    logic              act;
    logic              vld;
    logic              hold;
    logic [3:0]        lat;
    logic [3:0]        tot;
    logic [ADDR_W-1:0] a;
    logic [15:0]       dout;
    logic              rdy;
    logic              oe_d;
    logic              btog;
    logic              stog;
  } fbls_link_s;

  typedef struct packed {
    logic [2:0]            rq;
    logic                  pend;
    logic                  ack;
    fbls_pkg::fbls_state_e st;
    logic                  busy;
    logic                  susp;
    logic [TW-1:0]         tmr;
    logic [MEM_AW:0]       idx;
    logic [MEM_AW:0]       cnt;
    logic [MEM_AW:0]       bcnt;
    logic [MEM_AW-1:0]     base;
    logic [15:0]           data;
    logic                  chip;
    logic [BANK_W-1:0]     bbank;
    logic [SECT_W-1:0]     ssect;
    logic [WORDS-1:0][15:0] mem;
  } fbls_core_s;

  fbls_link_s        l;
  fbls_link_s        next_l;
  fbls_core_s        c;
  fbls_core_s        next_c;
  logic [1:0]        lrst_sy;
  logic              fin_valid;
  logic              fin_ready;
  logic              fout_valid;
  logic              fout_ready;
  logic [15:0]       fout_data;
  logic              pend;
  logic              acc_new;
  logic              acc_pulse;
  logic              ext;
  logic [ADDR_W-1:0] ta;
  logic [MEM_AW-1:0] wa;
  logic              take;

  // every 128th word and word zero count as a crossing
  function automatic logic is_bnd(input logic [ADDR_W-1:0] ra);
    return (ra[6:0] == fbls_pkg::BOUND_MASK) || (ra == '0); // RULE5
  endfunction

  // codes above five are reserved; they behave as five plus a boundary wait
  function automatic logic [3:0] lat_total(input logic [2:0] code);
    if (code > fbls_pkg::WAIT_MAX) begin
      return {1'b0, fbls_pkg::WAIT_MAX} + fbls_pkg::WAIT_EXTRA; // RULE6
    end
    return {1'b0, code} + fbls_pkg::WAIT_EXTRA; // RULE6
  endfunction

  // bank/sector ids are stable before the synchronised flag rises
  function automatic logic in_busy(input logic [ADDR_W-1:0] ra);
    return l.busy_sy[1] && !l.susp_sy[1] &&
      (ra[MEM_AW-1 -: BANK_W] == c.bbank); // RULE7
  endfunction

  function automatic logic in_susp(input logic [ADDR_W-1:0] ra);
    return l.susp_sy[1] && (ra[MEM_AW-1 -: SECT_W] == c.ssect); // RULE1
  endfunction

  function automatic logic [15:0] rd_word(input logic [ADDR_W-1:0] ra,
                                          input logic bt, input logic stg);
    logic [15:0] w;
    w = '0;
    if (in_busy(ra) || in_susp(ra)) begin
      w[fbls_pkg::BUSY_TOG_BIT] = bt;
      w[fbls_pkg::SUSP_TOG_BIT] = stg;
    end else begin
      w = c.mem[ra[MEM_AW-1:0]]; // RULE7 RULE13
    end
    return w;
  endfunction

  fbls_fifo #(
    .WIDTH (16),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (l.cdata),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  assign dq_out    = l.dout;
  assign dq_oe     = l.vld && !oe_n && !ce_n;
  assign rdy       = l.rdy;
  assign cmd_ready = !pend;
  assign pend      = l.req != l.ack_sy[1];

  // link side, on the host's burst clock
  always_comb begin
    next_l         = l;
    next_l.ack_sy  = {l.ack_sy[0], c.ack};
    next_l.busy_sy = {l.busy_sy[0], c.busy};
    next_l.susp_sy = {l.susp_sy[0], c.susp};
    next_l.oe_d    = oe_n;
    ext            = l.cfg[fbls_pkg::CFG_WAIT_LSB +: fbls_pkg::CFG_WAIT_W] > fbls_pkg::WAIT_MAX;
    acc_new        = !ce_n && !adv_n && we_n;
    acc_pulse      = acc_new || (!ce_n && oe_n && !l.oe_d); // RULE2
    ta             = acc_new ? addr : l.a;
    if (acc_pulse && in_busy(ta)) begin
      next_l.btog = !l.btog; // RULE13
    end
    if (acc_pulse && in_susp(ta)) begin
      next_l.stog = !l.stog; // RULE1
    end
    if (!ce_n && !we_n) begin
      if (fbls_pkg::fbls_cmd_e'(cmd_op) == fbls_pkg::CMD_SET_CFG) begin
        next_l.cfg = dq_in;
      end else if (!pend) begin
        next_l.req   = !l.req;
        next_l.op    = fbls_pkg::fbls_cmd_e'(cmd_op);
        next_l.caddr = addr;
        next_l.cdata = dq_in;
      end
    end
    if (ce_n) begin
      next_l.act  = 1'b0;
      next_l.vld  = 1'b0;
      next_l.hold = 1'b0;
    end else if (acc_new) begin
      next_l.act  = 1'b1;
      next_l.vld  = 1'b0;
      next_l.hold = 1'b0;
      next_l.a    = addr;
      next_l.lat  = 4'h1;
      next_l.tot  = lat_total(l.cfg[fbls_pkg::CFG_WAIT_LSB +: fbls_pkg::CFG_WAIT_W]) +
                    4'(ext && is_bnd(addr)); // RULE4 RULE5
    end else if (l.act && !l.vld) begin
      if (l.lat + 4'h1 >= l.tot) begin
        next_l.vld  = 1'b1;
        next_l.dout = rd_word(l.a, next_l.btog, next_l.stog);
      end else begin
        next_l.lat = l.lat + 4'h1;
      end
    end else if (l.vld) begin
      if (ext && is_bnd(l.a) && !l.hold) begin
        next_l.hold = 1'b1; // RULE4
      end else begin
        next_l.hold = 1'b0;
        next_l.a    = l.a + ADDR_W'(1);
        next_l.dout = rd_word(l.a + ADDR_W'(1), next_l.btog, next_l.stog);
      end
    end
    if (l.cfg[fbls_pkg::CFG_RDY_BIT]) begin
      next_l.rdy = next_l.vld && !next_l.hold; // RULE3
    end else begin
      next_l.rdy = next_l.act && (next_l.vld ?
        !(ext && is_bnd(next_l.a) && !next_l.hold) :
        (next_l.lat + 4'h1 >= next_l.tot)); // RULE3
    end
  end

  always_ff @(posedge burst_clk or posedge rst) begin
    if (rst) begin
      lrst_sy <= 2'h3;
    end else begin
      lrst_sy <= {lrst_sy[0], 1'b0};
    end
  end

  always_ff @(posedge burst_clk or posedge lrst_sy[1]) begin
    if (lrst_sy[1]) begin
      l     <= '0;
      l.cfg <= fbls_pkg::CFG_RESET;
      l.oe_d <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // embedded algorithm engine, on the system clock
  always_comb begin
    next_c     = c;
    fin_valid  = 1'b0;
    fout_ready = 1'b0;
    take       = 1'b0;
    wa         = c.base + c.idx[MEM_AW-1:0];
    next_c.rq  = {c.rq[1:0], l.req};
    if (c.rq[2] != c.rq[1]) begin
      next_c.pend = 1'b1;
    end
    if (c.pend) begin
      take = 1'b1;
      unique case (l.op)
        fbls_pkg::CMD_BUF_LOAD: begin
          fin_valid = c.st != fbls_pkg::ST_BUFPROG;
          take      = fin_valid && fin_ready;
          if (take) begin
            next_c.bcnt = c.bcnt + (MEM_AW+1)'(1);
          end
        end
        fbls_pkg::CMD_PROGRAM: begin
          if (c.st == fbls_pkg::ST_IDLE) begin
            next_c.st   = fbls_pkg::ST_PROG;
            next_c.tmr  = TW'(fbls_pkg::WORD_PROG_CYC); // RULE11
            next_c.base = l.caddr[MEM_AW-1:0];
            next_c.data = l.cdata;
            next_c.bbank = l.caddr[MEM_AW-1 -: BANK_W];
          end
        end
        fbls_pkg::CMD_BUF_COMMIT: begin
          if (c.st == fbls_pkg::ST_IDLE && c.bcnt != '0) begin
            next_c.st    = fbls_pkg::ST_BUFPROG;
            next_c.tmr   = BUF_PROG_CYCLES; // RULE12
            next_c.idx   = '0;
            next_c.base  = l.caddr[MEM_AW-1:0];
            next_c.bbank = l.caddr[MEM_AW-1 -: BANK_W];
          end
        end
        fbls_pkg::CMD_SECT_ERASE, fbls_pkg::CMD_CHIP_ERASE: begin
          if (c.st == fbls_pkg::ST_IDLE) begin
            next_c.st    = fbls_pkg::ST_PREPROG;
            next_c.idx   = '0;
            next_c.chip  = l.op == fbls_pkg::CMD_CHIP_ERASE;
            next_c.bbank = l.caddr[MEM_AW-1 -: BANK_W];
            next_c.ssect = l.caddr[MEM_AW-1 -: SECT_W];
            next_c.base  = next_c.chip ? '0 : {next_c.ssect, {(MEM_AW-SECT_W){1'b0}}};
            next_c.cnt   = next_c.chip ? (MEM_AW+1)'(WORDS) :
                           (MEM_AW+1)'(1) << (MEM_AW - SECT_W);
          end
        end
        fbls_pkg::CMD_SUSPEND: begin
          if (c.st == fbls_pkg::ST_ERASE && !c.chip) begin
            next_c.st = fbls_pkg::ST_SUSP;
          end
        end
        fbls_pkg::CMD_RESUME: begin
          if (c.st == fbls_pkg::ST_SUSP) begin
            next_c.st = fbls_pkg::ST_ERASE;
          end
        end
        fbls_pkg::CMD_SET_CFG: begin
        end
      endcase
      if (take) begin
        next_c.pend = 1'b0;
        next_c.ack  = !c.ack;
      end
    end
    unique case (c.st)
      fbls_pkg::ST_IDLE: begin
      end
      fbls_pkg::ST_PREPROG: begin
        next_c.mem[wa] = fbls_pkg::PREPROG_VAL; // RULE9
        next_c.idx     = c.idx + (MEM_AW+1)'(1);
        if (c.idx == c.cnt - (MEM_AW+1)'(1)) begin
          next_c.st  = fbls_pkg::ST_ERASE;
          next_c.idx = '0;
          next_c.tmr = c.chip ? CHIP_ERASE_CYCLES : SECT_ERASE_CYCLES; // RULE10
        end
      end
      fbls_pkg::ST_ERASE: begin
        if (c.tmr != '0) begin
          next_c.tmr = c.tmr - TW'(1);
        end else begin
          next_c.mem[wa] = fbls_pkg::ERASED_VAL;
          next_c.idx     = c.idx + (MEM_AW+1)'(1);
          if (c.idx == c.cnt - (MEM_AW+1)'(1)) begin
            next_c.st = fbls_pkg::ST_IDLE; // RULE13
          end
        end
      end
      fbls_pkg::ST_SUSP: begin
      end
      fbls_pkg::ST_PROG: begin
        if (c.tmr != '0) begin
          next_c.tmr = c.tmr - TW'(1);
        end else begin
          next_c.mem[c.base] = c.mem[c.base] & c.data; // RULE11
          next_c.st          = fbls_pkg::ST_IDLE;
        end
      end
      fbls_pkg::ST_BUFPROG: begin
        if (c.tmr != '0) begin
          next_c.tmr = c.tmr - TW'(1);
        end else begin
          fout_ready = 1'b1;
          if (fout_valid) begin
            next_c.mem[wa] = c.mem[wa] & fout_data; // RULE12
            next_c.idx     = c.idx + (MEM_AW+1)'(1);
            if (c.idx == c.bcnt - (MEM_AW+1)'(1)) begin
              next_c.st   = fbls_pkg::ST_IDLE;
              next_c.bcnt = '0;
            end
          end
        end
      end
      default: begin
        next_c.st = fbls_pkg::ST_IDLE;
      end
    endcase
    next_c.busy = next_c.st != fbls_pkg::ST_IDLE;
    next_c.susp = next_c.st == fbls_pkg::ST_SUSP;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c     <= '0;
      c.mem <= {WORDS{fbls_pkg::ERASED_VAL}};
    end else begin
      c <= next_c;
    end
  end
endmodule

// file: tb/fbls_top_properties.sv
// port-level checks for the burst flash timing and status block
`timescale 1ns/1ns
module fbls_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        burst_clk,
  input wire logic        ce_n,
  input wire logic        adv_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [23:0] addr,
  input wire logic [2:0]  cmd_op,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic        rdy,
  input wire logic        cmd_ready
);
  logic [15:0] cfg;
  logic [4:0]  cnt;
  logic [2:0]  wcode;
  logic        go;

  assign wcode = cfg[13:11];
  assign go    = !ce_n && !adv_n && we_n;

  // shadow of configuration, edges since burst start
  always_ff @(posedge burst_clk or posedge rst) begin
    if (rst) begin
      cfg <= fbls_pkg::CFG_RESET;
      cnt <= 5'h1F;
    end else begin
      if (!ce_n && !we_n && cmd_op == 3'h7) begin
        cfg <= dq_in;
      end
      if (go) begin
        cnt <= 5'h01;
      end else if (cnt != 5'h1F) begin
        cnt <= cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge burst_clk);
  endclocking
  default disable iff (rst);

  AST_LAT_DATA: assert property ($rose(rdy) && cfg[8] && wcode <= 3'h5
    |-> cnt == {2'h0, wcode} + 5'h02) else $error("rdy rose at wrong latency");
  AST_LAT_EARLY: assert property ($rose(rdy) && !cfg[8] && wcode <= 3'h5
    |-> cnt == {2'h0, wcode} + 5'h01) else $error("early rdy at wrong latency");
  AST_NO_BND_WAIT: assert property (rdy && !ce_n && adv_n && we_n && wcode <= 3'h5
    |=> rdy) else $error("rdy dropped inside burst");
  AST_BURST_END: assert property (ce_n |=> !rdy)
    else $error("rdy high after deselect");
  AST_RESTART: assert property (go && wcode >= 3'h3 |=> ##1 !rdy ##1 !rdy)
    else $error("rdy too soon after burst start");
  AST_CMD_TAKE: assert property (!ce_n && !we_n && cmd_ready && cmd_op != 3'h7
    |-> ##[1:2] !cmd_ready) else $error("command not taken");
  AST_CMD_ACK: assert property ($fell(cmd_ready) |-> ##[1:30] cmd_ready)
    else $error("command never acknowledged");
  AST_DQ_DRIVE: assert property (dq_oe && cfg[8] && wcode <= 3'h5 |-> rdy)
    else $error("data driven without rdy");
endmodule

bind fbls_top fbls_chk i_chk (.clk(clk), .rst(rst), .burst_clk(burst_clk), .ce_n(ce_n),
  .adv_n(adv_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .cmd_op(cmd_op), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy), .cmd_ready(cmd_ready));

// file: tb/fbls_host.sv
// host controller model driving the burst flash bus
`timescale 1ns/1ns
module fbls_host (
  output logic             burst_clk,
  output logic             ce_n,
  output logic             adv_n,
  output logic             oe_n,
  output logic             we_n,
  output logic      [23:0] addr,
  output logic      [2:0]  cmd_op,
  output logic      [15:0] dq_in,
  input  wire logic        rdy,
  input  wire logic        cmd_ready,
  input  wire logic [15:0] dq_out
);
  logic [15:0] cfg;
  logic [15:0] rdat [0:7];
  logic        drop;
  int          lat;

  initial begin
    {ce_n, adv_n, oe_n, we_n} = 4'hF;
    addr      = 24'h0;
    cmd_op    = 3'h0;
    dq_in     = 16'h0;
    cfg       = 16'h2900;
    burst_clk = 1'b0;
    #7;
    forever #16 burst_clk = ~burst_clk;
  end

  task automatic tick();
    @(posedge burst_clk);
    #2;
  endtask

  task automatic wr(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d);
    int i;
    for (i = 0; i < 200 && op != 3'h7 && cmd_ready !== 1'b1; i++) tick();
    if (i == 200) fbls_top_tb_top.test_done(1'b1);
    ce_n   = 1'b0;
    we_n   = 1'b0;
    cmd_op = op;
    addr   = a;
    dq_in  = d;
    if (op == 3'h7) cfg = d;
    tick();
    ce_n   = 1'b1;
    we_n   = 1'b1;
    cmd_op = ~op;
    addr   = ~a;
    dq_in  = ~d;
    tick();
  endtask

  task automatic rd(input logic [23:0] a, input int nw);
    int i;
    ce_n  = 1'b0;
    oe_n  = 1'b0;
    adv_n = 1'b0;
    addr  = a;
    tick();
    adv_n = 1'b1;
    addr  = ~a;
    drop  = 1'b0;
    lat   = 0;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) begin
      tick();
      lat++;
    end
    if (i == 20) fbls_top_tb_top.test_done(1'b1);
    if (!cfg[8]) tick();
    for (i = 0; i < nw; i++) begin
      rdat[i] = dq_out;
      if (rdy !== 1'b1) drop = 1'b1;
      tick();
    end
    ce_n = 1'b1;
    oe_n = 1'b1;
    tick();
  endtask

  // repeat status reads until two agree
  task automatic poll(input logic [23:0] a);
    logic [15:0] p;
    int          i;
    rd(a, 1);
    p = rdat[0];
    for (i = 0; i < 2000; i++) begin
      rd(a, 1);
      if (rdat[0] === p) break;
      p = rdat[0];
    end
    if (i == 2000) fbls_top_tb_top.test_done(1'b1);
  endtask
endmodule

// file: tb/fbls_top_tb_top.sv
// self-checking bench for the burst flash timing and status block
`timescale 1ns/1ns
module fbls_top_tb_top;
  logic        clk;
  logic        rst;
  logic        burst_clk;
  logic        ce_n;
  logic        adv_n;
  logic        oe_n;
  logic        we_n;
  logic [23:0] addr;
  logic [2:0]  cmd_op;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic        dq_oe;
  logic        rdy;
  logic        cmd_ready;
  int          mismatches;
  int          n_tests;

  fbls_top #(.BUF_PROG_CYCLES(36'h14), .SECT_ERASE_CYCLES(36'hBB8),
    .CHIP_ERASE_CYCLES(36'h64)) i_dut (.clk(clk), .rst(rst), .burst_clk(burst_clk),
    .ce_n(ce_n), .adv_n(adv_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .cmd_op(cmd_op),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy), .cmd_ready(cmd_ready));

  fbls_host i_host (.burst_clk(burst_clk), .ce_n(ce_n), .adv_n(adv_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .cmd_op(cmd_op), .dq_in(dq_in), .rdy(rdy),
    .cmd_ready(cmd_ready), .dq_out(dq_out));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done(input bit hung);
    if (hung) mismatches++;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    logic [15:0] s;
    int          c;
    int          b;
    time         t0;
    mismatches = 0;
    n_tests    = 0;
    rst        = 1'b1;
    repeat (10) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) i_host.tick();
    chk("cmd_ready", 16'h1, {15'h0, cmd_ready});
    chk("dq_oe", 16'h0, {15'h0, dq_oe});
    i_host.rd(24'h40, 1);
    chk("reset latency", 16'h6, 16'(i_host.lat));
    for (c = 3; c <= 5; c++) begin
      for (b = 0; b < 2; b++) begin
        i_host.wr(3'h7, 24'h0, {2'h0, c[2:0], 2'h0, b[0], 8'h0});
        i_host.rd(24'h40, 1);
        chk("latency", 16'(c + b), 16'(i_host.lat));
        chk("array", 16'hFFFF, i_host.rdat[0]);
      end
    end
    i_host.wr(3'h7, 24'h0, 16'h2900);
    t0 = $time;
    i_host.wr(3'h0, 24'h10, 16'h1234);
    i_host.rd(24'h10, 1);
    s = i_host.rdat[0];
    i_host.rd(24'h10, 1);
    chk("busy toggle", ~s & 16'h0040, i_host.rdat[0] & 16'h0040);
    i_host.rd(24'h50, 1);
    chk("other bank", 16'hFFFF, i_host.rdat[0]);
    i_host.poll(24'h10);
    t0 = $time - t0;
    chk("program time", 16'h1, {15'h0, t0 >= 40000 && t0 < 400000});
    i_host.rd(24'h10, 1);
    chk("programmed", 16'h1234, i_host.rdat[0]);
    for (c = 0; c < 32; c++) i_host.wr(3'h1, 24'h80, 16'hA000 + 16'(c));
    i_host.wr(3'h2, 24'h80, 16'h0);
    i_host.poll(24'h80);
    i_host.rd(24'h7E, 6);
    for (c = 0; c < 6; c++) begin
      chk("burst", c < 2 ? 16'hFFFF : 16'hA000 + 16'(c - 2), i_host.rdat[c]);
    end
    chk("rdy drop", 16'h0, {15'h0, i_host.drop});
    i_host.wr(3'h3, 24'h10, 16'h0);
    repeat (30) i_host.tick();
    i_host.wr(3'h5, 24'h10, 16'h0);
    repeat (30) i_host.tick();
    i_host.rd(24'h12, 1);
    s = i_host.rdat[0];
    i_host.rd(24'h12, 1);
    chk("suspend toggle", s ^ 16'h0004, i_host.rdat[0]);
    i_host.rd(24'h20, 1);
    chk("outside sector", 16'hFFFF, i_host.rdat[0]);
    i_host.wr(3'h6, 24'h10, 16'h0);
    i_host.poll(24'h10);
    i_host.rd(24'h10, 1);
    chk("erased", 16'hFFFF, i_host.rdat[0]);
    i_host.wr(3'h4, 24'h0, 16'h0);
    i_host.poll(24'h0);
    i_host.rd(24'h80, 1);
    chk("chip erased", 16'hFFFF, i_host.rdat[0]);
    test_done(1'b0);
  end
endmodule
